// [sos_pkg.sv]
package sos_pkg;
	// Clock rate and derived timing counts.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FB_WINDOW_MS = 500;
	localparam int unsigned SIMUL_WINDOW_MS = 500;
	localparam int unsigned LINK_EXTRA_MS = 20;
	localparam int unsigned LINK_DELAY_EXTRA_MS = 40;
	localparam int unsigned FB_WINDOW_CYC = FB_WINDOW_MS * (CLK_HZ / 1000);
	localparam int unsigned SIMUL_WINDOW_CYC =
		SIMUL_WINDOW_MS * (CLK_HZ / 1000);
	localparam int unsigned LINK_EXTRA_CYC = LINK_EXTRA_MS * (CLK_HZ / 1000);
	localparam int unsigned LINK_DELAY_EXTRA_CYC =
		LINK_DELAY_EXTRA_MS * (CLK_HZ / 1000);
	// Reference contour tolerance in millimetres.
	localparam logic [15:0] CONTOUR_TOL_MM = 16'h00c8;
	// Field select width and counter width.
	localparam int unsigned SEL_W = 10;
	localparam int unsigned PAIR_W = 7;
	localparam int unsigned CNT_W = 32;
	// Linkage modes.
	localparam logic [1:0] LINK_NONE = 2'h0;
	localparam logic [1:0] LINK_CONTACT = 2'h1;
	localparam logic [1:0] LINK_ELECTRONIC = 2'h2;
	// Fault codes shown on the display.
	localparam logic [3:0] FAULT_NONE = 4'h0;
	localparam logic [3:0] FAULT_FB_CLOSED = 4'h1;
	localparam logic [3:0] FAULT_FB_OPEN = 4'h2;
	localparam logic [3:0] FAULT_FB_RECLOSE = 4'h3;
	localparam logic [3:0] MSG_SIMUL = 4'h4;
	// Supervisor states.
	typedef enum logic [3:0] {
		SOS_OFF = 4'b0001,
		SOS_CHECK_OPEN = 4'b0010,
		SOS_ON = 4'b0100,
		SOS_FAULT = 4'b1000
	} sos_state_t;
endpackage

// [sos_simul_check.sv]
// Two-channel simultaneity checker for upstream contacts or output channels.
module sos_simul_check (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [31:0] window_cyc_i,
	input wire logic ch_a_i,
	input wire logic ch_b_i,
	output logic ok_o,
	output logic mismatch_o
);
	import sos_pkg::*;
	logic [31:0] cnt_q, cnt_d;
	logic ok_q, ok_d;
	logic bad_q, bad_d;

	// After both open, the second channel must close within the window after the first closes to be accepted.
	always_comb begin
		cnt_d = cnt_q;
		ok_d = ok_q;
		bad_d = 1'b0;
		if (!ch_a_i && !ch_b_i) begin
			cnt_d = '0;
			ok_d = 1'b0;
		end else if (ch_a_i && ch_b_i) begin
			if (!ok_q && cnt_q <= window_cyc_i)
				ok_d = 1'b1;
		end else begin
			ok_d = 1'b0;
			if (cnt_q <= window_cyc_i)
				cnt_d = cnt_q + 32'h1;
			if (cnt_q == window_cyc_i)
				bad_d = 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			ok_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ok_q <= ok_d;
			bad_q <= bad_d;
		end
	end
	assign ok_o = ok_q;
	assign mismatch_o = bad_q;
endmodule

// [sos_supervisor.sv]
// What this block does
// - Impermissible field-pair changeover switches outputs off
// - Changeover to deactivated pair switches off while order_check_en_i is set
// - Contour deviation beyond 200 mm switches off
// - Standby mode suspends monitoring, outputs off
// - Secondary outputs are delayed copy of primary
// - No restart until delay fully elapsed
// - Feedback closed required before every switch-on
// - Feedback opens within 500 ms after release
// - Feedback recloses within 500 ms after off
// - Failed feedback check forces fault interlock
// - Linkage adds 20 ms response delay
// - Linkage with delay adds up to 40 ms
// - Contact linkage needs both contacts closed together
// - Electronic linkage needs both upstream channels on
// - Upstream channels off force outputs off
// - Indication signals with configurable mapping
// - Changeover interval keeps old pair monitored
module sos_supervisor (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [sos_pkg::SEL_W-1:0] field_select_i,
	input wire logic [31:0] changeover_cyc_i,
	input wire logic order_check_en_i,
	input wire logic transition_ok_i,
	input wire logic target_deactivated_i,
	input wire logic contour_present_i,
	input wire logic [15:0] contour_dev_mm_i,
	input wire logic standby_i,
	input wire logic field_free_i,
	input wire logic warn_violated_i,
	input wire logic single_function_i,
	input wire logic [31:0] delay_cyc_i,
	input wire logic fb_monitor_en_i,
	input wire logic contactor_feedback_input_i,
	input wire logic [1:0] link_mode_i,
	input wire logic link_a_i,
	input wire logic link_b_i,
	input wire logic restart_i,
	input wire logic [7:0] signal_map_i,
	output logic [1:0] primary_safety_outputs_o,
	output logic [1:0] secondary_safety_outputs_o,
	output logic [sos_pkg::SEL_W-1:0] active_select_o,
	output logic changeover_active_o,
	output logic fault_interlock_o,
	output logic [3:0] display_code_o,
	output logic [1:0] indication_o
);
	import sos_pkg::*;

	// Field select, feedback and both link pins pass two flip-flops before use.
	localparam int unsigned NSYNC = SEL_W + 3;
	logic [NSYNC-1:0] raw, s1_q, s2_q;
	assign raw = {field_select_i, contactor_feedback_input_i,
		link_a_i, link_b_i};
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	logic [SEL_W-1:0] sel_s;
	logic fb_s, la_s, lb_s;
	assign sel_s = s2_q[NSYNC-1:3];
	assign fb_s = s2_q[2];
	assign la_s = s2_q[1];
	assign lb_s = s2_q[0];

	// Changeover: old selection stays in force until the interval ends.
	logic [SEL_W-1:0] act_q, act_d, last_q, last_d;
	logic [31:0] co_q, co_d;
	logic co_run_q, co_run_d, co_trip;
	always_comb begin
		act_d = act_q;
		last_d = sel_s;
		co_d = co_q;
		co_run_d = co_run_q;
		co_trip = 1'b0;
		if (sel_s != last_q) begin
			co_run_d = 1'b1;
			co_d = '0;
		end else if (co_run_q) begin
			if (co_q >= changeover_cyc_i) begin
				co_run_d = 1'b0;
				act_d = sel_s;
				co_trip = order_check_en_i &&
					(!transition_ok_i || target_deactivated_i);
			end else
				co_d = co_q + 32'h1;
		end
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			act_q <= '0;
			last_q <= '0;
			co_q <= '0;
			co_run_q <= 1'b0;
		end else begin
			act_q <= act_d;
			last_q <= last_d;
			co_q <= co_d;
			co_run_q <= co_run_d;
		end
	end

	// Linkage simultaneity checking.
	logic link_ok, link_bad;
	sos_simul_check u_simul (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.window_cyc_i(SIMUL_WINDOW_CYC),
		.ch_a_i(la_s),
		.ch_b_i(lb_s),
		.ok_o(link_ok),
		.mismatch_o(link_bad)
	);
	logic link_en;
	assign link_en = (link_mode_i == LINK_CONTACT) ||
		(link_mode_i == LINK_ELECTRONIC);

	// Linked demand is held back by the extra response time so that the
	// link path cannot switch off faster than the documented budget.
	logic [31:0] lk_q, lk_d;
	logic link_drop;
	always_comb begin
		lk_d = '0;
		if (link_en && !link_ok) begin
			lk_d = lk_q;
			if (lk_q < LINK_EXTRA_CYC)
				lk_d = lk_q + 32'h1;
		end
	end
	assign link_drop = link_en && !link_ok &&
		lk_q >= LINK_EXTRA_CYC - 1;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			lk_q <= '0;
		else
			lk_q <= lk_d;
	end

	// Combined switch-on permission.
	logic contour_bad, permit, trip;
	assign contour_bad = contour_present_i &&
		contour_dev_mm_i > CONTOUR_TOL_MM;
	assign permit = field_free_i && !contour_bad && !standby_i &&
		(!link_en || link_ok);
	assign trip = co_trip || contour_bad || standby_i || link_drop ||
		!field_free_i;

	// Main supervisor with feedback monitoring and fault interlock.
	logic delay_busy, restart_ok;
	sos_state_t st_q, st_d;
	logic [31:0] fw_q, fw_d;
	logic rc_q, rc_d;
	logic [3:0] code_q, code_d;
	always_comb begin
		st_d = st_q;
		fw_d = fw_q;
		rc_d = rc_q;
		code_d = code_q;
		if (link_bad)
			code_d = MSG_SIMUL;
		// A pending reclose check is dropped once monitoring is turned off.
		// Otherwise a stale check would resume once monitoring is back on.
		if (rc_q) begin
			if (!fb_monitor_en_i || fb_s)
				rc_d = 1'b0;
			else if (fw_q >= FB_WINDOW_CYC)
				rc_d = 1'b0;
		end
		unique case (st_q)
			SOS_OFF: begin
				if (rc_q && fb_monitor_en_i && !fb_s &&
					fw_q >= FB_WINDOW_CYC) begin
					st_d = SOS_FAULT;
					code_d = FAULT_FB_RECLOSE;
				end else if (rc_q && fb_monitor_en_i)
					fw_d = fw_q + 32'h1;
				else if (permit && !delay_busy && restart_ok) begin
					if (fb_monitor_en_i && !fb_s) begin
						st_d = SOS_FAULT;
						code_d = FAULT_FB_CLOSED;
					end else begin
						st_d = fb_monitor_en_i ? SOS_CHECK_OPEN : SOS_ON;
						fw_d = '0;
					end
				end
			end
			SOS_CHECK_OPEN: begin
				fw_d = fw_q + 32'h1;
				if (trip) begin
					st_d = SOS_OFF;
					fw_d = '0;
					rc_d = 1'b1;
				end else if (!fb_s)
					st_d = SOS_ON;
				else if (fw_q >= FB_WINDOW_CYC) begin
					st_d = SOS_FAULT;
					code_d = FAULT_FB_OPEN;
				end
			end
			SOS_ON: begin
				if (trip) begin
					st_d = SOS_OFF;
					fw_d = '0;
					rc_d = fb_monitor_en_i;
				end
			end
			SOS_FAULT: begin
				if (restart_i) begin
					st_d = SOS_OFF;
					code_d = FAULT_NONE;
					rc_d = 1'b0;
				end
			end
			default: st_d = SOS_FAULT;
		endcase
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= SOS_OFF;
			fw_q <= '0;
			rc_q <= 1'b0;
			code_q <= FAULT_NONE;
		end else begin
			st_q <= st_d;
			fw_q <= fw_d;
			rc_q <= rc_d;
			code_q <= code_d;
		end
	end

	// Delayed secondary channel; linkage stretches the delay budget.
	logic [31:0] dl_q, dl_d, dl_lim;
	logic sec_q, sec_d, prim_on;
	assign prim_on = (st_q == SOS_ON) || (st_q == SOS_CHECK_OPEN);
	assign dl_lim = link_en ? delay_cyc_i + LINK_DELAY_EXTRA_CYC
		: delay_cyc_i;
	assign delay_busy = single_function_i && sec_q && !prim_on;
	assign restart_ok = !single_function_i || !sec_q;
	always_comb begin
		dl_d = '0;
		sec_d = prim_on;
		if (single_function_i && !prim_on && sec_q) begin
			dl_d = dl_q + 32'h1;
			sec_d = dl_q < dl_lim;
		end else if (!single_function_i)
			sec_d = prim_on;
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dl_q <= '0;
			sec_q <= 1'b0;
		end else begin
			dl_q <= dl_d;
			sec_q <= sec_d;
		end
	end

	// Indication outputs with configurable source mapping.
	logic [3:0] ind_src;
	logic [1:0] ind_q, ind_d;
	assign ind_src = {st_q == SOS_FAULT, co_run_q, warn_violated_i,
		!field_free_i};
	always_comb begin
		ind_d[0] = ind_src[signal_map_i[1:0]];
		ind_d[1] = ind_src[signal_map_i[5:4]];
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			ind_q <= '0;
		else
			ind_q <= ind_d;
	end

	assign primary_safety_outputs_o = {2{prim_on}};
	assign secondary_safety_outputs_o = {2{sec_q}};
	assign active_select_o = act_q;
	assign changeover_active_o = co_run_q;
	assign fault_interlock_o = (st_q == SOS_FAULT);
	assign display_code_o = code_q;
	assign indication_o = ind_q;

	// Fault state must hold outputs off until restart is asked for.
	AST_FAULT_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
		(st_q == SOS_FAULT && !restart_i) |=> st_q == SOS_FAULT)
		else $error("fault interlock left without restart");
	AST_FAULT_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
		st_q == SOS_FAULT |-> primary_safety_outputs_o == 2'h0)
		else $error("outputs on in fault interlock");
	AST_STANDBY: assert property (@(posedge clock_i) disable iff (rst_i)
		standby_i |=> !(st_q == SOS_ON))
		else $error("outputs on in standby");
	AST_CONTOUR: assert property (@(posedge clock_i) disable iff (rst_i)
		contour_bad |=> st_q != SOS_ON)
		else $error("contour deviation did not switch off");
	AST_ON_NEEDS_FB: assert property (@(posedge clock_i) disable iff (rst_i)
		(st_q == SOS_OFF && fb_monitor_en_i && !fb_s) |=>
		st_q != SOS_CHECK_OPEN)
		else $error("switch-on with feedback open");
	AST_CO_TRIP: assert property (@(posedge clock_i) disable iff (rst_i)
		co_trip |=> st_q != SOS_ON)
		else $error("bad changeover did not switch off");
	AST_SEC_FOLLOW: assert property (@(posedge clock_i) disable iff (rst_i)
		(!single_function_i && prim_on) |=> sec_q)
		else $error("secondary did not follow primary");
	AST_LINK_ON: assert property (@(posedge clock_i) disable iff (rst_i)
		(link_en && !link_ok && st_q == SOS_OFF) |=> st_q == SOS_OFF ||
		st_q == SOS_FAULT)
		else $error("switch-on without linkage");
endmodule

// [sos_contactor_model.sv]
// Downstream contactor with a positively guided feedback contact.
module sos_contactor_model #(
	parameter int unsigned DELAY_CYC = 3
) (
	input wire logic clock_i,
	input wire logic [1:0] coil_i,
	input wire logic stuck_open_i,
	output logic feedback_o
);
	logic [DELAY_CYC-1:0] pipe_q;

	// The contact follows the coil after a mechanical lag, so the device
	// sees the loop close and open a few cycles late, as a real relay does.
	always_ff @(posedge clock_i) begin
		pipe_q <= {pipe_q[DELAY_CYC-2:0], ~(&coil_i)};
	end

	// Closed loop drives high while released; a welded or broken contact
	// is modelled by holding the loop open on command.
	assign feedback_o = pipe_q[DELAY_CYC-1] & ~stuck_open_i;
endmodule

// [tb_safety_output_supervisor.sv]
module tb_safety_output_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	import sos_pkg::*;
	typedef struct packed {
		logic sb;
		logic cp;
		logic [15:0] dev;
		logic ff;
		logic on;
	} sos_row_t;
	logic clock_i, rst_i, order_check_en_i, transition_ok_i;
	logic target_deactivated_i, contour_present_i, standby_i;
	logic field_free_i, warn_violated_i, single_function_i;
	logic fb_monitor_en_i, fb, link_a_i, link_b_i, restart_i, stuck;
	logic [9:0] field_select_i, active_select_o;
	logic [31:0] changeover_cyc_i, delay_cyc_i;
	logic [15:0] contour_dev_mm_i;
	logic [1:0] link_mode_i, primary, secondary, indication_o;
	logic [7:0] signal_map_i;
	logic changeover_active_o, fault_interlock_o;
	logic [3:0] display_code_o;
	int error_cnt = 0;
	int samples_checked = 0;
	// Ordinary trip cases: standby, contour just over and at tolerance.
	sos_row_t rows [5] = '{'{1'b1, 1'b0, 16'h0000, 1'b1, 1'b0},
		'{1'b0, 1'b1, 16'h00c9, 1'b1, 1'b0},
		'{1'b0, 1'b1, 16'h00c8, 1'b1, 1'b1},
		'{1'b0, 1'b0, 16'h0fff, 1'b1, 1'b1},
		'{1'b0, 1'b0, 16'h0000, 1'b0, 1'b0}};

	sos_supervisor i_dut (
		.clock_i(clock_i), .rst_i(rst_i),
		.field_select_i(field_select_i),
		.changeover_cyc_i(changeover_cyc_i),
		.order_check_en_i(order_check_en_i),
		.transition_ok_i(transition_ok_i),
		.target_deactivated_i(target_deactivated_i),
		.contour_present_i(contour_present_i),
		.contour_dev_mm_i(contour_dev_mm_i), .standby_i(standby_i),
		.field_free_i(field_free_i), .warn_violated_i(warn_violated_i),
		.single_function_i(single_function_i),
		.delay_cyc_i(delay_cyc_i), .fb_monitor_en_i(fb_monitor_en_i),
		.contactor_feedback_input_i(fb), .link_mode_i(link_mode_i),
		.link_a_i(link_a_i), .link_b_i(link_b_i), .restart_i(restart_i),
		.signal_map_i(signal_map_i),
		.primary_safety_outputs_o(primary),
		.secondary_safety_outputs_o(secondary),
		.active_select_o(active_select_o),
		.changeover_active_o(changeover_active_o),
		.fault_interlock_o(fault_interlock_o),
		.display_code_o(display_code_o), .indication_o(indication_o)
	);

	sos_contactor_model i_contactor (
		.clock_i(clock_i), .coil_i(primary), .stuck_open_i(stuck),
		.feedback_o(fb)
	);

	// Free-running system clock at 100 MHz.
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Inputs move 1 ns after the edge so no race with the sampling edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	// Bounded wait for switch-on; the caller judges the outcome.
	task automatic wait_on(input int n);
		for (int i = 0; i < n && primary !== 2'b11; i++) cyc(1);
	endtask

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// The whole sequence needs at most about 1150 cycles; this is a wide margin.
	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		end_of_test();
	end

	initial begin
		{order_check_en_i, target_deactivated_i, contour_present_i} = '0;
		{standby_i, field_free_i, warn_violated_i, single_function_i} = '0;
		{link_a_i, link_b_i, restart_i, stuck} = '0;
		{transition_ok_i, fb_monitor_en_i, rst_i} = 3'h7;
		field_select_i = 10'h001;
		changeover_cyc_i = 32'h0000_0014;
		delay_cyc_i = 32'h0000_0032;
		contour_dev_mm_i = 16'h0000;
		link_mode_i = LINK_NONE;
		signal_map_i = 8'h10;
		repeat (6) @(posedge clock_i);
		#1;
		chk({primary, secondary, fault_interlock_o} === '0, "reset");
		rst_i = 1'b0;
		// The synchronised feedback reads open for two cycles after reset.
		cyc(3);
		field_free_i = 1'b1;
		wait_on(40);
		chk(primary === 2'b11, "first switch-on");
		foreach (rows[i]) begin
			{standby_i, contour_present_i} = {rows[i].sb, rows[i].cp};
			{contour_dev_mm_i, field_free_i} = {rows[i].dev, rows[i].ff};
			cyc(10);
			chk(primary === {2{rows[i].on}}, "trip row");
			{standby_i, contour_present_i, field_free_i} = 3'h1;
			wait_on(60);
		end
		// Loop held open while released: switch-on must be refused.
		field_free_i = 1'b0;
		cyc(10);
		stuck = 1'b1;
		cyc(5);
		field_free_i = 1'b1;
		cyc(30);
		chk(primary === 2'b00, "on with open loop");
		chk(display_code_o === FAULT_FB_CLOSED, "fault code");
		stuck = 1'b0;
		cyc(10);
		chk(fault_interlock_o === 1'b1, "interlock held");
		restart_i = 1'b1;
		cyc(1);
		restart_i = 1'b0;
		wait_on(40);
		chk(primary === 2'b11, "on after loop closed");
		single_function_i = 1'b1;
		cyc(60);
		chk(secondary === 2'b11, "secondary on");
		field_free_i = 1'b0;
		cyc(30);
		chk(secondary === 2'b11, "secondary early off");
		cyc(30);
		chk(secondary === 2'b00, "secondary late");
		field_free_i = 1'b1;
		wait_on(80);
		field_free_i = 1'b0;
		cyc(5);
		field_free_i = 1'b1;
		cyc(25);
		chk(primary === 2'b00, "restart in delay");
		wait_on(80);
		chk(primary === 2'b11, "restart after delay");
		single_function_i = 1'b0;
		// Second upstream channel arrives late but inside the window.
		for (int m = 1; m < 3; m++) begin
			{field_free_i, link_b_i} = 2'h0;
			cyc(5);
			link_mode_i = 2'(m);
			{link_a_i, field_free_i} = 2'h3;
			cyc(30);
			chk(primary === 2'b00, "one channel");
			link_b_i = 1'b1;
			wait_on(40);
			chk(primary === 2'b11, "both channels");
		end
		link_mode_i = LINK_NONE;
		order_check_en_i = 1'b1;
		field_select_i = 10'h002;
		cyc(8);
		chk(changeover_active_o === 1'b1, "changeover flag");
		chk(active_select_o === 10'h001, "old pair kept");
		cyc(40);
		chk(active_select_o === 10'h002, "new pair");
		chk(primary === 2'b11, "permitted changeover");
		target_deactivated_i = 1'b1;
		field_select_i = 10'h004;
		// The trip lasts only until the loop recloses, so look inside it.
		cyc(27);
		chk(primary === 2'b00, "deactivated target");
		target_deactivated_i = 1'b0;
		wait_on(60);
		transition_ok_i = 1'b0;
		field_select_i = 10'h008;
		cyc(27);
		chk(primary === 2'b00, "forbidden changeover");
		{order_check_en_i, transition_ok_i} = 2'h1;
		{field_free_i, warn_violated_i} = 2'h1;
		for (int s = 0; s < 4; s++) begin
			signal_map_i = {2'h0, 2'(3 - s), 2'h0, 2'(s)};
			cyc(5);
			chk(indication_o === {3 - s < 2, s < 2}, "map");
		end
		chk(fault_interlock_o === 1'b0, "no fault");
		rst_i = 1'b1;
		cyc(2);
		chk({primary, display_code_o, indication_o} === '0, "reset 2");
		rst_i = 1'b0;
		cyc(5);
		end_of_test();
	end
endmodule
